/* src/pcs_align_defs.svh */
// constants for the receive lane alignment status block
`ifndef PCS_ALIGN_DEFS_SVH
`define PCS_ALIGN_DEFS_SVH

`define NUM_LANES       20
`define LANE_IDX_W      5
`define MF_CYCLES_DFLT  16384

`define ADDR_W          8
`define OFS_CTRL        8'h00
`define OFS_STATUS      8'h04
`define OFS_IRQ_STAT    8'h08
`define OFS_IRQ_MASK    8'h0c
`define OFS_BLOCK_LOCK  8'h10
`define OFS_SYNCED      8'h14

`define CTRL_EN_BIT     0
`define CTRL_RST        1'h1
`define HSIZE_WORD      3'h2
`define HTRANS_NONSEQ   1

`define ST_ALIGNED      0
`define ST_PCS_OK       1
`define ST_ALIGN_ERR    2
`define ST_LOCAL_FAULT  3
`define ST_REMOTE_FAULT 4

`define IRQ_W           5
`define IRQ_MARKER_ERR  0
`define IRQ_MISALIGN    1
`define IRQ_ALIGN_UP    2
`define IRQ_ALIGN_LOSS  3
`define IRQ_REMOTE      4

`endif

/* src/pcs_align_pkg.sv */
// shared types for the receive lane alignment status block
`include "pcs_align_defs.svh"

package pcs_align_pkg;
	typedef logic [`LANE_IDX_W-1:0]            lane_idx_t;
	typedef logic [`NUM_LANES-1:0]             lane_vec_t;
	typedef logic [`NUM_LANES*`LANE_IDX_W-1:0] lane_idx_flat_t;
	typedef logic [`IRQ_W-1:0]                 irq_vec_t;
endpackage

/* src/pcs_lane_track.sv */
// per pcs lane tracker: physical lane mapping, sync, marker error, lock
`timescale 1ns/10ps
`include "pcs_align_defs.svh"

module pcs_lane_track #(
	parameter int unsigned LANE = 0
) (
	input  wire logic                         sys_clk,
	input  wire logic                         resetn,
	input  wire logic                         enable,
	input  wire pcs_align_pkg::lane_vec_t      phys_block_lock,
	input  wire pcs_align_pkg::lane_vec_t      phys_word_sync,
	input  wire pcs_align_pkg::lane_vec_t      phys_marker_valid,
	input  wire pcs_align_pkg::lane_vec_t      phys_marker_bad,
	input  wire pcs_align_pkg::lane_idx_flat_t phys_marker_lane,
	output pcs_align_pkg::lane_idx_t          phys_index,
	output logic                              synced,
	output logic                              marker_err,
	output logic                              block_lock
);
	import pcs_align_pkg::*;

	typedef struct packed {
		lane_idx_t idx;
		logic      seen;
		logic      synced;
		logic      err;
		logic      lock;
	} track_t;

	track_t s_q;
	track_t s_d;

	always_comb begin
		logic hit;
		hit = 1'b0;
		s_d = s_q;
		// a lost word boundary forgets the marker until the next one
		if (!phys_word_sync[s_q.idx]) begin
			s_d.seen = 1'b0;
		end
		// lowest physical lane wins if two claim this lane at once
		for (int q = `NUM_LANES - 1; q >= 0; q--) begin
			if (phys_marker_valid[q] &&
			    phys_marker_lane[q*`LANE_IDX_W +: `LANE_IDX_W] ==
			    `LANE_IDX_W'(LANE)) begin
				hit = 1'b1;
				s_d.idx = `LANE_IDX_W'(q);
			end
		end
		if (hit) begin
			s_d.seen = 1'b1;
		end
		s_d.synced = s_q.seen && phys_word_sync[s_q.idx];
		s_d.err = s_q.seen && phys_marker_bad[s_q.idx];
		s_d.lock = phys_block_lock[LANE];
		if (!enable) begin
			s_d = '0;
		end
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign phys_index = s_q.idx;
	assign synced     = s_q.synced;
	assign marker_err = s_q.err;
	assign block_lock = s_q.lock;
endmodule // pcs_lane_track

/* src/pcs_lane_alignment_status.sv */
// receive lane alignment status with ahb-lite registers and interrupt
//
// Overview of operation
// - Each lane pulses its marker word error bit one cycle per malformed marker.
// - Aligned output is a level, high while every lane is aligned and de-skewed.
// - Aligned low is reported as a local fault on the receive path; the code holds local fault low while the enable bit is clear.
// - Pcs status is high only while aligned and not in high error rate state.
// - Twenty block lock bits, one per lane, high while that lane is locked.
// - Alignment lost level rises on an alignment error or loss of alignment.
// - Misaligned pulses one cycle when expected markers fail across the lanes.
// - No misaligned pulse before all lanes aligned once and a bad marker came.
// - Misaligned pulse follows the bad marker by one meta-frame.
// - Remote fault output is a level, high while a remote fault is detected.
// - Twenty 5-bit outputs give the physical lane carrying each pcs lane.
// - A lane's physical index is valid only while its sync bit is high.
// - Each sync bit is high once word-synced and a lane marker was received.
//
// Local design decisions: the address map and register access over AHB-Lite.
`timescale 1ns/10ps
`include "pcs_align_defs.svh"

module pcs_lane_alignment_status #(
	parameter int unsigned MF_CYCLES = `MF_CYCLES_DFLT
) (
	input  wire logic                         sys_clk,
	input  wire logic                         resetn,
	// ahb-lite slave
	input  wire logic                         hsel,
	input  wire logic [31:0]                  haddr,
	input  wire logic [1:0]                   htrans,
	input  wire logic                         hwrite,
	input  wire logic [2:0]                   hsize,
	input  wire logic [31:0]                  hwdata,
	input  wire logic                         hready,
	output logic                              hreadyout,
	output logic                              hresp,
	output logic [31:0]                       hrdata,
	output logic                              irq,
	// receive datapath, per physical lane, then link-wide flags
	input  wire pcs_align_pkg::lane_vec_t      phys_block_lock,
	input  wire pcs_align_pkg::lane_vec_t      phys_word_sync,
	input  wire pcs_align_pkg::lane_vec_t      phys_marker_valid,
	input  wire pcs_align_pkg::lane_vec_t      phys_marker_bad,
	input  wire pcs_align_pkg::lane_idx_flat_t phys_marker_lane,
	input  wire logic                         deskew_done,
	input  wire logic                         deskew_error,
	input  wire logic                         high_error_rate_state,
	input  wire logic                         remote_fault_detect,
	// status
	output pcs_align_pkg::lane_vec_t          lane_marker_word_error,
	output logic                              all_lanes_aligned,
	output logic                              pcs_status,
	output pcs_align_pkg::lane_vec_t          lane_block_lock,
	output logic                              alignment_lost,
	output logic                              misaligned,
	output logic                              remote_fault,
	output logic                              local_fault,
	output pcs_align_pkg::lane_vec_t          lane_word_synced,
	output pcs_align_pkg::lane_idx_t          pcs_lane0_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane1_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane2_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane3_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane4_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane5_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane6_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane7_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane8_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane9_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane10_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane11_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane12_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane13_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane14_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane15_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane16_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane17_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane18_phys_index,
	output pcs_align_pkg::lane_idx_t          pcs_lane19_phys_index
);
	import pcs_align_pkg::*;

	localparam int unsigned MF_W = $clog2(MF_CYCLES + 1);

	typedef struct packed {
		// bus side
		logic                  wr_pend;
		logic [`ADDR_W-1:0]    wr_addr;
		logic [31:0]           rdata;
		logic                  enable;
		irq_vec_t              irq_stat;
		irq_vec_t              irq_mask;
		logic                  irq;
		// alignment status
		logic                  aligned;
		logic                  pcs_ok;
		logic                  align_err;
		logic                  local_fault;
		logic                  remote_fault;
		logic                  ever_aligned;
		logic                  mf_pend;
		logic [MF_W-1:0]       mf_cnt;
		logic                  misaligned;
	} state_t;

	state_t s_q;
	state_t s_d;

	lane_idx_t idx_arr [`NUM_LANES];
	lane_vec_t synced_vec;
	lane_vec_t err_vec;
	lane_vec_t lock_vec;

	genvar g;
	generate
		for (g = 0; g < `NUM_LANES; g++) begin : g_lane
			pcs_lane_track #(
				.LANE (g)
			) u_track (
				.sys_clk           (sys_clk),
				.resetn            (resetn),
				.enable            (s_q.enable),
				.phys_block_lock   (phys_block_lock),
				.phys_word_sync    (phys_word_sync),
				.phys_marker_valid (phys_marker_valid),
				.phys_marker_bad   (phys_marker_bad),
				.phys_marker_lane  (phys_marker_lane),
				.phys_index        (idx_arr[g]),
				.synced            (synced_vec[g]),
				.marker_err        (err_vec[g]),
				.block_lock        (lock_vec[g])
			);
		end
	endgenerate

	// register read mux, sampled in the address phase
	function automatic logic [31:0] read_mux(
		input logic [`ADDR_W-1:0] a,
		input state_t             s,
		input lane_vec_t          lk,
		input lane_vec_t          sy
	);
		logic [31:0] r;
		r = 32'h0;
		unique case (a)
			`OFS_CTRL: begin
				r[`CTRL_EN_BIT] = s.enable;
			end
			`OFS_STATUS: begin
				r[`ST_ALIGNED]      = s.aligned;
				r[`ST_PCS_OK]       = s.pcs_ok;
				r[`ST_ALIGN_ERR]    = s.align_err;
				r[`ST_LOCAL_FAULT]  = s.local_fault;
				r[`ST_REMOTE_FAULT] = s.remote_fault;
			end
			`OFS_IRQ_STAT: begin
				r[`IRQ_W-1:0] = s.irq_stat;
			end
			`OFS_IRQ_MASK: begin
				r[`IRQ_W-1:0] = s.irq_mask;
			end
			`OFS_BLOCK_LOCK: begin
				r[`NUM_LANES-1:0] = lk;
			end
			`OFS_SYNCED: begin
				r[`NUM_LANES-1:0] = sy;
			end
			default: begin
				r = 32'h0;
			end
		endcase
		return r;
	endfunction

	always_comb begin
		logic     addr_ok;
		logic     all_up;
		logic     any_err;
		logic     mf_done;
		irq_vec_t ev;
		irq_vec_t clr;
		addr_ok = 1'b0;
		all_up  = 1'b0;
		any_err = 1'b0;
		mf_done = 1'b0;
		ev      = '0;
		clr     = '0;
		s_d     = s_q;

		// data phase of a write: the word lands at the end of this cycle
		s_d.wr_pend = 1'b0;
		if (s_q.wr_pend) begin
			unique case (s_q.wr_addr)
				`OFS_CTRL: begin
					s_d.enable = hwdata[`CTRL_EN_BIT];
				end
				`OFS_IRQ_STAT: begin
					clr = hwdata[`IRQ_W-1:0];
				end
				`OFS_IRQ_MASK: begin
					s_d.irq_mask = hwdata[`IRQ_W-1:0];
				end
				default: begin
				end
			endcase
		end

		// address phase; partial writes are not supported and dropped
		addr_ok = hsel && hready && htrans[`HTRANS_NONSEQ];
		if (addr_ok && hwrite && hsize == `HSIZE_WORD) begin
			s_d.wr_pend = 1'b1;
			s_d.wr_addr = haddr[`ADDR_W-1:0];
		end
		if (addr_ok && !hwrite) begin
			s_d.rdata = read_mux(haddr[`ADDR_W-1:0], s_q, lock_vec,
			                     synced_vec);
		end

		// alignment: every lane synced, locked and the deskew settled
		all_up = (&synced_vec) && (&lock_vec) && deskew_done;
		s_d.aligned = all_up;
		s_d.local_fault = !all_up;
		s_d.pcs_ok = all_up && !high_error_rate_state;
		s_d.remote_fault = remote_fault_detect;
		// loss after success, or a deskew failure, raises the flag
		if (deskew_error || (s_q.aligned && !all_up)) begin
			s_d.align_err = 1'b1;
		end else if (all_up) begin
			s_d.align_err = 1'b0;
		end
		if (s_q.aligned) begin
			s_d.ever_aligned = 1'b1;
		end

		// misalignment: one pending meta-frame timer, not a queue
		any_err = |err_vec;
		s_d.misaligned = 1'b0;
		mf_done = s_q.mf_pend &&
		          s_q.mf_cnt == MF_W'(MF_CYCLES - 1);
		if (s_q.mf_pend) begin
			s_d.mf_cnt = s_q.mf_cnt + MF_W'(1);
		end
		if (mf_done) begin
			s_d.misaligned = 1'b1;
			s_d.mf_pend = 1'b0;
		end
		if (s_q.ever_aligned && any_err &&
		    (!s_q.mf_pend || mf_done)) begin
			s_d.mf_pend = 1'b1;
			s_d.mf_cnt = '0;
		end

		// sticky events; a new event beats a same-cycle clear
		ev[`IRQ_MARKER_ERR] = any_err;
		ev[`IRQ_MISALIGN]   = mf_done;
		ev[`IRQ_ALIGN_UP]   = all_up && !s_q.aligned;
		ev[`IRQ_ALIGN_LOSS] = s_q.aligned && !all_up;
		ev[`IRQ_REMOTE]     = remote_fault_detect && !s_q.remote_fault;

		if (!s_q.enable) begin
			s_d.aligned      = 1'b0;
			s_d.local_fault  = 1'b0;
			s_d.pcs_ok       = 1'b0;
			s_d.remote_fault = 1'b0;
			s_d.align_err    = 1'b0;
			s_d.ever_aligned = 1'b0;
			s_d.mf_pend      = 1'b0;
			s_d.mf_cnt       = '0;
			s_d.misaligned   = 1'b0;
			ev               = '0;
		end
		s_d.irq_stat = (s_q.irq_stat & ~clr) | ev;
		s_d.irq = |(s_d.irq_stat & s_d.irq_mask);
	end

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			s_q        <= '0;
			s_q.enable <= `CTRL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// zero wait states, never an error response
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = s_q.rdata;
	assign irq       = s_q.irq;

	assign lane_marker_word_error = err_vec;
	assign lane_block_lock        = lock_vec;
	assign lane_word_synced       = synced_vec;
	assign all_lanes_aligned      = s_q.aligned;
	assign pcs_status             = s_q.pcs_ok;
	assign alignment_lost         = s_q.align_err;
	assign misaligned             = s_q.misaligned;
	assign remote_fault           = s_q.remote_fault;
	assign local_fault            = s_q.local_fault;

	// index outputs are only meaningful with the matching sync bit
	assign pcs_lane0_phys_index  = idx_arr[0];
	assign pcs_lane1_phys_index  = idx_arr[1];
	assign pcs_lane2_phys_index  = idx_arr[2];
	assign pcs_lane3_phys_index  = idx_arr[3];
	assign pcs_lane4_phys_index  = idx_arr[4];
	assign pcs_lane5_phys_index  = idx_arr[5];
	assign pcs_lane6_phys_index  = idx_arr[6];
	assign pcs_lane7_phys_index  = idx_arr[7];
	assign pcs_lane8_phys_index  = idx_arr[8];
	assign pcs_lane9_phys_index  = idx_arr[9];
	assign pcs_lane10_phys_index = idx_arr[10];
	assign pcs_lane11_phys_index = idx_arr[11];
	assign pcs_lane12_phys_index = idx_arr[12];
	assign pcs_lane13_phys_index = idx_arr[13];
	assign pcs_lane14_phys_index = idx_arr[14];
	assign pcs_lane15_phys_index = idx_arr[15];
	assign pcs_lane16_phys_index = idx_arr[16];
	assign pcs_lane17_phys_index = idx_arr[17];
	assign pcs_lane18_phys_index = idx_arr[18];
	assign pcs_lane19_phys_index = idx_arr[19];
endmodule // pcs_lane_alignment_status

/* tb/pcs_align_chk.sv */
// assertions on the lane alignment status outputs
`timescale 1ns/10ps
`include "pcs_align_defs.svh"

module pcs_align_chk #(
	parameter int unsigned MF_CYCLES = `MF_CYCLES_DFLT
) (
	input wire logic                     sys_clk,
	input wire logic                     resetn,
	input wire pcs_align_pkg::lane_vec_t phys_block_lock,
	input wire pcs_align_pkg::lane_vec_t phys_marker_bad,
	input wire logic                     deskew_done,
	input wire logic                     high_error_rate_state,
	input wire logic                     remote_fault_detect,
	input wire pcs_align_pkg::lane_vec_t lane_marker_word_error,
	input wire logic                     all_lanes_aligned,
	input wire logic                     pcs_status,
	input wire pcs_align_pkg::lane_vec_t lane_block_lock,
	input wire logic                     alignment_lost,
	input wire logic                     misaligned,
	input wire logic                     remote_fault,
	input wire logic                     local_fault,
	input wire pcs_align_pkg::lane_vec_t lane_word_synced
);
	import pcs_align_pkg::*;
	logic seen_q;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	// weaker than the design's flag: enable low is never modelled here
	always_ff @(posedge sys_clk or negedge resetn)
		if (!resetn) seen_q <= 1'b0;
		else if (all_lanes_aligned) seen_q <= 1'b1;
	property p_err_cause;
		|lane_marker_word_error |-> |$past(phys_marker_bad);
	endproperty
	a_err_cause: assert property (p_err_cause)
		else $error("marker error without a bad marker");
	property p_aligned;
		all_lanes_aligned |-> $past(deskew_done) && &$past(lane_word_synced);
	endproperty
	a_aligned: assert property (p_aligned)
		else $error("aligned while lanes not synced or skewed");
	property p_local;
		all_lanes_aligned |-> !local_fault;
	endproperty
	a_local: assert property (p_local)
		else $error("local fault while aligned");
	property p_status;
		pcs_status == (all_lanes_aligned && !$past(high_error_rate_state));
	endproperty
	a_status: assert property (p_status)
		else $error("pcs status disagrees with alignment and error rate");
	property p_lock;
		lane_block_lock == $past(phys_block_lock);
	endproperty
	a_lock: assert property (p_lock)
		else $error("block lock does not follow its lane");
	property p_lost;
		$fell(all_lanes_aligned) |-> ##[0:1] alignment_lost;
	endproperty
	a_lost: assert property (p_lost)
		else $error("alignment lost not raised after loss");
	property p_mis_pulse;
		misaligned |=> !misaligned;
	endproperty
	a_mis_pulse: assert property (p_mis_pulse)
		else $error("misaligned longer than one cycle");
	property p_mis_armed;
		misaligned |-> seen_q;
	endproperty
	a_mis_armed: assert property (p_mis_armed)
		else $error("misaligned before alignment was ever reached");
	property p_mis_delay;
		misaligned |-> |$past(lane_marker_word_error, MF_CYCLES + 1);
	endproperty
	a_mis_delay: assert property (p_mis_delay)
		else $error("misaligned not one meta-frame after a marker error");
	property p_remote;
		remote_fault == $past(remote_fault_detect);
	endproperty
	a_remote: assert property (p_remote)
		else $error("remote fault does not follow detection");
	property p_reset;
		$rose(resetn) |-> !all_lanes_aligned && !pcs_status && !misaligned
			&& lane_word_synced == '0 && lane_block_lock == '0;
	endproperty
	a_reset: assert property (p_reset)
		else $error("status not cleared by reset");
	c_mis: cover property (misaligned);
	c_loss: cover property ($fell(all_lanes_aligned));
	c_sync: cover property (&lane_word_synced);
endmodule // pcs_align_chk

bind pcs_lane_alignment_status pcs_align_chk #(.MF_CYCLES(MF_CYCLES))
	u_pcs_align_chk (.sys_clk, .resetn, .phys_block_lock, .phys_marker_bad,
	.deskew_done, .high_error_rate_state, .remote_fault_detect,
	.lane_marker_word_error, .all_lanes_aligned, .pcs_status,
	.lane_block_lock, .alignment_lost, .misaligned, .remote_fault,
	.local_fault, .lane_word_synced);

/* tb/link_partner_model.sv */
// link partner model: per lane lock, word sync and lane markers
`timescale 1ns/10ps
`include "pcs_align_defs.svh"

module link_partner_model (
	input  wire logic                     sys_clk,
	input  wire logic                     lock_en,
	input  wire logic                     mark_en,
	input  wire pcs_align_pkg::lane_vec_t bad_req,
	output pcs_align_pkg::lane_vec_t      phys_block_lock,
	output pcs_align_pkg::lane_vec_t      phys_word_sync,
	output pcs_align_pkg::lane_vec_t      phys_marker_valid,
	output pcs_align_pkg::lane_vec_t      phys_marker_bad,
	output pcs_align_pkg::lane_idx_flat_t phys_marker_lane
);
	import pcs_align_pkg::*;
	logic [1:0] slot_q = 2'h0;
	lane_vec_t  pend_q = '0;
	initial begin
		phys_marker_valid = '0;
		phys_marker_bad = '0;
		phys_marker_lane = '0;
	end
	assign phys_block_lock = lock_en ? '1 : '0;
	assign phys_word_sync = lock_en ? '1 : '0;
	always @(posedge sys_clk) begin
		slot_q <= slot_q + 2'h1;
		pend_q <= pend_q | bad_req;
		phys_marker_valid <= '0;
		phys_marker_bad <= '0;
		if (mark_en && slot_q == 2'h3) begin
			phys_marker_valid <= ~pend_q;
			phys_marker_bad <= pend_q;
			pend_q <= bad_req;
		end
		// lanes wired in reverse; id toggles between markers as junk
		for (int q = 0; q < `NUM_LANES; q++)
			phys_marker_lane[5*q +: 5] <= (mark_en && slot_q == 2'h3) ?
				5'(`NUM_LANES - 1 - q) : ~phys_marker_lane[5*q +: 5];
	end
endmodule // link_partner_model

/* tb/tb_top.sv */
// testbench for the receive lane alignment status block
`timescale 1ns/10ps
`include "pcs_align_defs.svh"

module tb_top;
	import pcs_align_pkg::*;
	localparam int unsigned MF = 16;
	logic           sys_clk = 1'b0;
	logic           resetn = 1'b0;
	logic           hsel = 1'b0;
	logic           hwrite = 1'b0;
	logic [31:0]    haddr = '0;
	logic [31:0]    hwdata = '0;
	logic [1:0]     htrans = 2'h0;
	logic [2:0]     hsize = 3'h2;
	logic [31:0]    hrdata, rd;
	logic           hready, hreadyout, hresp, irq;
	logic           deskew_done = 1'b0;
	logic           deskew_error = 1'b0;
	logic           high_error_rate_state = 1'b0;
	logic           remote_fault_detect = 1'b0;
	logic           lock_en = 1'b0;
	logic           mark_en = 1'b0;
	lane_vec_t      bad_req = '0;
	lane_vec_t      phys_block_lock, phys_word_sync, phys_marker_valid;
	lane_vec_t      phys_marker_bad, lane_marker_word_error;
	lane_vec_t      lane_block_lock, lane_word_synced;
	lane_idx_flat_t phys_marker_lane;
	lane_idx_flat_t idx_all;
	logic           all_lanes_aligned, pcs_status, alignment_lost;
	logic           misaligned, remote_fault, local_fault;
	lane_idx_t      pcs_lane0_phys_index, pcs_lane1_phys_index;
	lane_idx_t      pcs_lane2_phys_index, pcs_lane3_phys_index;
	lane_idx_t      pcs_lane4_phys_index, pcs_lane5_phys_index;
	lane_idx_t      pcs_lane6_phys_index, pcs_lane7_phys_index;
	lane_idx_t      pcs_lane8_phys_index, pcs_lane9_phys_index;
	lane_idx_t      pcs_lane10_phys_index, pcs_lane11_phys_index;
	lane_idx_t      pcs_lane12_phys_index, pcs_lane13_phys_index;
	lane_idx_t      pcs_lane14_phys_index, pcs_lane15_phys_index;
	lane_idx_t      pcs_lane16_phys_index, pcs_lane17_phys_index;
	lane_idx_t      pcs_lane18_phys_index, pcs_lane19_phys_index;
	int             err_total = 0;
	int             checks = 0;
	int             n;

	assign hready = hreadyout;
	// pcs lane n sits at bits 5n up, so one loop sees every index output
	assign idx_all = {pcs_lane19_phys_index, pcs_lane18_phys_index,
		pcs_lane17_phys_index, pcs_lane16_phys_index,
		pcs_lane15_phys_index, pcs_lane14_phys_index,
		pcs_lane13_phys_index, pcs_lane12_phys_index,
		pcs_lane11_phys_index, pcs_lane10_phys_index,
		pcs_lane9_phys_index, pcs_lane8_phys_index,
		pcs_lane7_phys_index, pcs_lane6_phys_index,
		pcs_lane5_phys_index, pcs_lane4_phys_index,
		pcs_lane3_phys_index, pcs_lane2_phys_index,
		pcs_lane1_phys_index, pcs_lane0_phys_index};
	always #20 sys_clk = ~sys_clk;
	pcs_lane_alignment_status #(.MF_CYCLES(MF))
		u_pcs_lane_alignment_status (.*);
	link_partner_model u_link_partner_model (.*);

	task automatic wc(input int k);
		repeat (k) @(posedge sys_clk);
		#1;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks++;
		if (g !== e) begin
			err_total++;
			$display("unexpected %s: expected %h seen %h", nm, e, g);
		end
	endtask
	// single word transfer; waits on hready in both phases
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge sys_clk); while (hreadyout !== 1'b1);
		rd = hrdata;
		#1;
	endtask
	task automatic summarize();
		$display("checks %0d err_total %0d", checks, err_total);
		if (err_total == 0 && checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	initial begin
		#(3000 * 40);
		err_total++;
		summarize();
	end

	initial begin
		wc(3);
		chk("aligned_rst", 32'h0, 32'(all_lanes_aligned));
		wc(3);
		resetn <= 1'b1;
		wc(1);
		bus(0, `OFS_CTRL, 32'h0);
		chk("ctrl", 32'h1, rd);
		lock_en <= 1'b1;
		mark_en <= 1'b1;
		deskew_done <= 1'b1;
		wc(12);
		chk("block_lock", 32'hfffff, 32'(lane_block_lock));
		chk("synced", 32'hfffff, 32'(lane_word_synced));
		chk("idx0", 32'h13, 32'(pcs_lane0_phys_index));
		chk("idx7", 32'h0c, 32'(pcs_lane7_phys_index));
		// partner wires physical lane q to pcs lane 19 - q
		for (int q = 0; q < `NUM_LANES; q++)
			chk("idx", 32'(`NUM_LANES-1-q), 32'(idx_all[5*q +: 5]));
		chk("local_fault", 32'h0, 32'(local_fault));
		bus(0, `OFS_STATUS, 32'h0);
		chk("status", 32'h3, rd);
		high_error_rate_state <= 1'b1;
		wc(3);
		chk("pcs_status_her", 32'h0, 32'(pcs_status));
		chk("aligned_her", 32'h1, 32'(all_lanes_aligned));
		high_error_rate_state <= 1'b0;
		bus(1, `OFS_IRQ_MASK, 32'h1f);
		bus(1, `OFS_IRQ_STAT, 32'h1f);
		wc(2);
		chk("irq_clear", 32'h0, 32'(irq));
		bad_req <= 20'h80000;
		wc(1);
		bad_req <= '0;
		n = 0;
		while (lane_marker_word_error === '0 && n < 20) begin
			wc(1);
			n++;
		end
		chk("marker_err", 32'h1, 32'(lane_marker_word_error));
		n = 0;
		while (misaligned !== 1'b1 && n < 40) begin
			wc(1);
			n++;
		end
		chk("mis_delay", MF + 1, n);
		wc(1);
		chk("mis_pulse", 32'h0, 32'(misaligned));
		bus(0, `OFS_IRQ_STAT, 32'h0);
		chk("irq_stat", 32'h3, rd);
		chk("irq_up", 32'h1, 32'(irq));
		bus(1, `OFS_IRQ_STAT, 32'h3);
		wc(2);
		chk("irq_w1c", 32'h0, 32'(irq));
		remote_fault_detect <= 1'b1;
		wc(2);
		chk("remote_on", 32'h1, 32'(remote_fault));
		bus(1, `OFS_IRQ_MASK, 32'h0);
		wc(2);
		chk("irq_masked", 32'h0, 32'(irq));
		bus(0, `OFS_IRQ_STAT, 32'h0);
		chk("irq_remote", 32'h10, rd);
		remote_fault_detect <= 1'b0;
		deskew_done <= 1'b0;
		deskew_error <= 1'b1;
		wc(1);
		deskew_error <= 1'b0;
		wc(3);
		chk("remote_off", 32'h0, 32'(remote_fault));
		chk("aligned_lost", 32'h0, 32'(all_lanes_aligned));
		chk("lost", 32'h1, 32'(alignment_lost));
		chk("local_on", 32'h1, 32'(local_fault));
		lock_en <= 1'b0;
		wc(3);
		chk("unsynced", 32'h0, 32'(lane_word_synced));
		chk("unlocked", 32'h0, 32'(lane_block_lock));
		bus(0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("hresp", 32'h0, 32'(hresp));
		resetn <= 1'b0;
		wc(2);
		chk("lost_rst", 32'h0, 32'(alignment_lost));
		resetn <= 1'b1;
		lock_en <= 1'b1;
		bad_req <= 20'h1;
		wc(1);
		bad_req <= '0;
		n = 0;
		repeat (40) begin
			wc(1);
			if (misaligned === 1'b1)
				n++;
		end
		chk("mis_unarmed", 32'h0, n);
		// never aligned here, so only the deskew error can raise the flag
		deskew_error <= 1'b1;
		wc(1);
		deskew_error <= 1'b0;
		wc(1);
		chk("lost_err", 32'h1, 32'(alignment_lost));
		chk("local_en", 32'h1, 32'(local_fault));
		// lock dropped first so the lock follower stays consistent
		lock_en <= 1'b0;
		bus(1, `OFS_CTRL, 32'h0);
		bus(0, `OFS_CTRL, 32'h0);
		chk("ctrl_off", 32'h0, rd);
		chk("local_off", 32'h0, 32'(local_fault));
		chk("lost_off", 32'h0, 32'(alignment_lost));
		summarize();
	end
endmodule // tb_top
